/* File: common/bsw_pkg.sv */
package bsw_pkg;

  // Port 0 is the upstream port, ports 1 to NPORT-1 face downstream devices.
  localparam int          NPORT        = 4;
  localparam int          PORT_W       = 2;

  // Configuration dword byte offsets handled by this bank.
  localparam logic [7:0]  OFF_PF_BASE_HI = 8'h28;
  localparam logic [7:0]  OFF_PF_LIM_HI  = 8'h2C;
  localparam logic [7:0]  OFF_IO_HI      = 8'h30;
  localparam logic [7:0]  OFF_CAP_PTR    = 8'h34;
  localparam logic [7:0]  OFF_IRQ_BCTL   = 8'h3C;

  // Values after reset and fixed read values.
  localparam logic [31:0] PF_HI_RST      = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RST      = 16'h0000;
  localparam logic [7:0]  CAP_PTR_VAL    = 8'h40;
  localparam logic [7:0]  IRQ_LINE_RST   = 8'h00;
  localparam logic [7:0]  IRQ_PIN_RST    = 8'h00;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // Bridge control is held as bits 22:16 of the 0x3C dword.
  localparam int          BCTL_LSB       = 16;
  localparam int          BCTL_W         = 7;
  localparam logic [6:0]  BCTL_RST       = 7'h00;
  localparam logic [6:0]  BCTL_WMASK     = 7'h5F;
  localparam int          BC_PERR        = 0;
  localparam int          BC_SERR        = 1;
  localparam int          BC_ISA         = 2;
  localparam int          BC_VGA         = 3;
  localparam int          BC_VGA16       = 4;
  localparam int          BC_SBR         = 6;

  // Implied low address bits of the assembled windows.
  localparam logic [19:0] PF_LOW_BASE    = 20'h0_0000;
  localparam logic [19:0] PF_LOW_LIM     = 20'hF_FFFF;
  localparam logic [11:0] IO_LOW_BASE    = 12'h000;
  localparam logic [11:0] IO_LOW_LIM     = 12'hFFF;

  // Legacy display decode ranges.
  localparam logic [63:0] VGA_MEM_LO     = 64'h0000_0000_000A_0000;
  localparam logic [63:0] VGA_MEM_HI     = 64'h0000_0000_000B_FFFF;
  localparam logic [9:0]  VGA_IO_A_LO    = 10'h3B0;
  localparam logic [9:0]  VGA_IO_A_HI    = 10'h3BB;
  localparam logic [9:0]  VGA_IO_B_LO    = 10'h3C0;
  localparam logic [9:0]  VGA_IO_B_HI    = 10'h3DF;

endpackage : bsw_pkg

/* File: common/bsw_dec_if.sv */
`timescale 1ns/10ps
interface bsw_dec_if;
  logic        is_io;
  logic [63:0] addr;
  logic [63:0] pf_base;
  logic [63:0] pf_lim;
  logic [31:0] io_base;
  logic [31:0] io_lim;
  logic        isa_en;
  logic        vga_en;
  logic        vga16;
  logic        win_hit;
  logic        vga_hit;

  modport ctl (output is_io, addr, pf_base, pf_lim, io_base, io_lim, isa_en, vga_en, vga16,
               input  win_hit, vga_hit);
  modport dec (input  is_io, addr, pf_base, pf_lim, io_base, io_lim, isa_en, vga_en, vga16,
               output win_hit, vga_hit);
endinterface : bsw_dec_if

/* File: rtl/bsw_fwd_decode.sv */
`timescale 1ns/10ps
module bsw_fwd_decode (
  bsw_dec_if.dec d
);

  logic first64k;
  logic io_in;
  logic isa_blk;
  logic mem_in;
  logic vga_io10;
  logic vga_io;
  logic vga_mem;

  always_comb begin
    first64k = (d.addr[63:16] == 48'h0000_0000_0000);
    // Inclusive compares make a limit below the base an empty window.
    io_in    = (d.addr[63:32] == 32'h0000_0000) && (d.addr[31:0] >= d.io_base) &&
               (d.addr[31:0] <= d.io_lim);
    mem_in   = (d.addr >= d.pf_base) && (d.addr <= d.pf_lim);
    // Only the top 768 bytes of each 1KB block pass in the first 64KB.
    isa_blk  = d.isa_en && first64k && (d.addr[9:8] == 2'b00);
    vga_io10 = ((d.addr[9:0] >= bsw_pkg::VGA_IO_A_LO) && (d.addr[9:0] <= bsw_pkg::VGA_IO_A_HI)) ||
               ((d.addr[9:0] >= bsw_pkg::VGA_IO_B_LO) && (d.addr[9:0] <= bsw_pkg::VGA_IO_B_HI));
    vga_io   = d.vga_en && first64k && vga_io10 &&
               (!d.vga16 || (d.addr[15:10] == 6'h00));
    vga_mem  = d.vga_en && (d.addr >= bsw_pkg::VGA_MEM_LO) &&
               (d.addr <= bsw_pkg::VGA_MEM_HI);
    d.win_hit = d.is_io ? (io_in && !isa_blk) : mem_in;
    d.vga_hit = d.is_io ? vga_io : vga_mem;
  end

endmodule : bsw_fwd_decode

/* File: rtl/bsw_irq_pin_init.sv */
`timescale 1ns/10ps
module bsw_irq_pin_init (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ld_vld_i,
  input  wire logic [7:0] ld_val_i,
  output logic      [7:0] pin_o
);

  logic [7:0] pin_q;

  // The default may be replaced at initialisation by the sideband loader.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_q <= bsw_pkg::IRQ_PIN_RST;
    end else if (ld_vld_i) begin
      pin_q <= ld_val_i;
    end
  end

  assign pin_o = pin_q;

  chk_pin_load_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ld_vld_i |=> (pin_q == $past(ld_val_i)))
    else $error("interrupt pin default not loaded");

endmodule : bsw_irq_pin_init

/* File: rtl/bsw_bridge_regs.sv */
`timescale 1ns/10ps
// Functional notes
// - Prefetch limit upper dword, writable, reset zero.
// - I/O base upper half at 0x30 low.
// - I/O limit upper half at 0x30 high.
// - Capability pointer reads fixed 40h.
// - Interrupt pin byte read-only, reset 00h.
// - Downstream interrupt pin default loadable at init.
// - Bit 16 enables secondary poisoned TLP reporting.
// - Bit 17 gates secondary error message forwarding.
// - Bit 18 limits low I/O to top 768 bytes.
// - Bit 19 forwards legacy display memory range.
// - Display I/O ranges forwarded when bit 19 set.
// - Bit 20 selects 10 or 16 bit decode.
// - Bit 22 drives downstream port hot reset.
// - Upstream bit 22 resets every downstream port.
// - Bits 21, 23 to 31 read zero.
// - Implied low bits: base zeros, limit ones.
// - Prefetch base upper dword at 28h, writable.
module bsw_bridge_regs (
  input  wire logic                                  mclk_i,
  input  wire logic                                  sys_rst_i,
  input  wire logic                                  cfg_req_i,
  input  wire logic                                  cfg_wr_i,
  input  wire logic [bsw_pkg::PORT_W-1:0]            cfg_port_i,
  input  wire logic [7:0]                            cfg_addr_i,
  input  wire logic [3:0]                            cfg_be_i,
  input  wire logic [31:0]                           cfg_wdata_i,
  output logic                                       cfg_ack_o,
  output logic      [31:0]                           cfg_rdata_o,
  input  wire logic                                  init_ld_vld_i,
  input  wire logic [bsw_pkg::PORT_W-1:0]            init_ld_port_i,
  input  wire logic [7:0]                            init_ld_pin_i,
  input  wire logic [bsw_pkg::NPORT-1:0][11:0]       pf_base_lo_i,
  input  wire logic [bsw_pkg::NPORT-1:0][11:0]       pf_lim_lo_i,
  input  wire logic [bsw_pkg::NPORT-1:0][3:0]        io_base_lo_i,
  input  wire logic [bsw_pkg::NPORT-1:0][3:0]        io_lim_lo_i,
  input  wire logic                                  txn_req_i,
  input  wire logic [bsw_pkg::PORT_W-1:0]            txn_port_i,
  input  wire logic                                  txn_is_io_i,
  input  wire logic [63:0]                           txn_addr_i,
  output logic                                       fwd_vld_o,
  output logic                                       fwd_hit_o,
  output logic                                       fwd_vga_o,
  input  wire logic [bsw_pkg::NPORT-1:0]             sec_poison_i,
  output logic      [bsw_pkg::NPORT-1:0]             poison_report_o,
  input  wire logic [bsw_pkg::NPORT-1:0]             sec_err_msg_i,
  output logic                                       pri_err_msg_o,
  output logic      [bsw_pkg::NPORT-2:0]             hot_rst_n_o
);

  localparam int NP = bsw_pkg::NPORT;

  logic [NP-1:0][31:0]              pf_base_hi_q;
  logic [NP-1:0][31:0]              pf_lim_hi_q;
  logic [NP-1:0][15:0]              io_base_hi_q;
  logic [NP-1:0][15:0]              io_lim_hi_q;
  logic [NP-1:0][7:0]               irq_line_q;
  logic [NP-1:0][bsw_pkg::BCTL_W-1:0] bctl_q;
  logic [NP-1:0][7:0]               pin_w;
  logic [7:0]                       cfg_dw;
  logic                             wr_hit;
  logic [31:0]                      io_cur;
  logic [31:0]                      io_new;
  logic [31:0]                      ibc_cur;
  logic [31:0]                      ibc_new;
  logic [31:0]                      rdata_d;
  logic                             cfg_ack_q;
  logic [31:0]                      cfg_rdata_q;
  logic                             fwd_vld_q;
  logic                             fwd_hit_q;
  logic                             fwd_vga_q;
  logic [NP-1:0]                    poison_q;
  logic [NP-1:0]                    err_en;
  logic                             pri_err_q;
  logic [NP-2:0]                    hot_rst_n_q;

  bsw_dec_if dec_if ();

  // Byte enables merge the new data into the current dword lane by lane.
  function automatic logic [31:0] merge_be(input logic [31:0] cur,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = cur;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  assign cfg_dw = {cfg_addr_i[7:2], 2'b00};
  assign wr_hit = cfg_req_i && cfg_wr_i;

  // The upstream port reports no interrupt wire; only downstream pins are loadable.
  assign pin_w[0] = bsw_pkg::IRQ_PIN_RST;

  for (genvar p = 1; p < NP; p++) begin : g_pin
    bsw_irq_pin_init u_pin (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .ld_vld_i  (init_ld_vld_i && (init_ld_port_i == bsw_pkg::PORT_W'(p))),
      .ld_val_i  (init_ld_pin_i),
      .pin_o     (pin_w[p])
    );
  end

  always_comb begin
    io_cur  = {io_lim_hi_q[cfg_port_i], io_base_hi_q[cfg_port_i]};
    io_new  = merge_be(io_cur, cfg_wdata_i, cfg_be_i);
    ibc_cur = {9'h000, bctl_q[cfg_port_i], pin_w[cfg_port_i], irq_line_q[cfg_port_i]};
    ibc_new = merge_be(ibc_cur, cfg_wdata_i, cfg_be_i);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pf_base_hi_q <= {NP{bsw_pkg::PF_HI_RST}};
    end else if (wr_hit && (cfg_dw == bsw_pkg::OFF_PF_BASE_HI)) begin
      pf_base_hi_q[cfg_port_i] <= merge_be(pf_base_hi_q[cfg_port_i], cfg_wdata_i, cfg_be_i);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pf_lim_hi_q <= {NP{bsw_pkg::PF_HI_RST}};
    end else if (wr_hit && (cfg_dw == bsw_pkg::OFF_PF_LIM_HI)) begin
      pf_lim_hi_q[cfg_port_i] <= merge_be(pf_lim_hi_q[cfg_port_i], cfg_wdata_i, cfg_be_i);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      io_base_hi_q <= {NP{bsw_pkg::IO_HI_RST}};
      io_lim_hi_q  <= {NP{bsw_pkg::IO_HI_RST}};
    end else if (wr_hit && (cfg_dw == bsw_pkg::OFF_IO_HI)) begin
      io_base_hi_q[cfg_port_i] <= io_new[15:0];
      io_lim_hi_q[cfg_port_i]  <= io_new[31:16];
    end
  end

  // The pin byte and the hardwired control bits ignore writes.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_line_q <= {NP{bsw_pkg::IRQ_LINE_RST}};
      bctl_q     <= {NP{bsw_pkg::BCTL_RST}};
    end else if (wr_hit && (cfg_dw == bsw_pkg::OFF_IRQ_BCTL)) begin
      irq_line_q[cfg_port_i] <= ibc_new[7:0];
      bctl_q[cfg_port_i]     <= ibc_new[bsw_pkg::BCTL_LSB +: bsw_pkg::BCTL_W] &
                                bsw_pkg::BCTL_WMASK;
    end
  end

  // Offsets outside this bank read zero and ignore writes.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (cfg_dw)
      bsw_pkg::OFF_PF_BASE_HI: rdata_d = pf_base_hi_q[cfg_port_i];
      bsw_pkg::OFF_PF_LIM_HI:  rdata_d = pf_lim_hi_q[cfg_port_i];
      bsw_pkg::OFF_IO_HI:      rdata_d = io_cur;
      bsw_pkg::OFF_CAP_PTR:    rdata_d = {24'h00_0000, bsw_pkg::CAP_PTR_VAL};
      bsw_pkg::OFF_IRQ_BCTL:   rdata_d = ibc_cur;
      default:                 rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= bsw_pkg::RDATA_RST;
    end else begin
      cfg_ack_q   <= cfg_req_i;
      cfg_rdata_q <= (cfg_req_i && !cfg_wr_i) ? rdata_d : bsw_pkg::RDATA_RST;
    end
  end

  // Window assembly with the implied low bits for the selected port.
  assign dec_if.is_io   = txn_is_io_i;
  assign dec_if.addr    = txn_addr_i;
  assign dec_if.pf_base = {pf_base_hi_q[txn_port_i], pf_base_lo_i[txn_port_i],
                           bsw_pkg::PF_LOW_BASE};
  assign dec_if.pf_lim  = {pf_lim_hi_q[txn_port_i], pf_lim_lo_i[txn_port_i],
                           bsw_pkg::PF_LOW_LIM};
  assign dec_if.io_base = {io_base_hi_q[txn_port_i], io_base_lo_i[txn_port_i],
                           bsw_pkg::IO_LOW_BASE};
  assign dec_if.io_lim  = {io_lim_hi_q[txn_port_i], io_lim_lo_i[txn_port_i],
                           bsw_pkg::IO_LOW_LIM};
  assign dec_if.isa_en  = bctl_q[txn_port_i][bsw_pkg::BC_ISA];
  assign dec_if.vga_en  = bctl_q[txn_port_i][bsw_pkg::BC_VGA];
  assign dec_if.vga16   = bctl_q[txn_port_i][bsw_pkg::BC_VGA16];

  bsw_fwd_decode u_dec (
    .d (dec_if.dec)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fwd_vld_q <= 1'b0;
      fwd_hit_q <= 1'b0;
      fwd_vga_q <= 1'b0;
    end else begin
      fwd_vld_q <= txn_req_i;
      fwd_hit_q <= txn_req_i && dec_if.win_hit;
      fwd_vga_q <= txn_req_i && dec_if.vga_hit;
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_en
    assign err_en[p] = bctl_q[p][bsw_pkg::BC_SERR];
  end

  // Poison and error gating are registered so every output is a flop.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      poison_q  <= '0;
      pri_err_q <= 1'b0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        poison_q[p] <= sec_poison_i[p] && bctl_q[p][bsw_pkg::BC_PERR];
      end
      pri_err_q <= |(sec_err_msg_i & err_en);
    end
  end

  // The upstream bit resets all downstream ports together; each port bit its own.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hot_rst_n_q <= '1;
    end else begin
      for (int p = 1; p < NP; p++) begin
        hot_rst_n_q[p-1] <= !(bctl_q[p][bsw_pkg::BC_SBR] ||
                              bctl_q[0][bsw_pkg::BC_SBR]);
      end
    end
  end

  assign cfg_ack_o       = cfg_ack_q;
  assign cfg_rdata_o     = cfg_rdata_q;
  assign fwd_vld_o       = fwd_vld_q;
  assign fwd_hit_o       = fwd_hit_q;
  assign fwd_vga_o       = fwd_vga_q;
  assign poison_report_o = poison_q;
  assign pri_err_msg_o   = pri_err_q;
  assign hot_rst_n_o     = hot_rst_n_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_full_wr(logic [7:0] off);
    cfg_req_i && cfg_wr_i && (cfg_dw == off) && (cfg_be_i == 4'hF);
  endsequence

  // Software usually sets the reset bit with a single byte-lane write.
  sequence s_up_sbr_set;
    cfg_req_i && cfg_wr_i && (cfg_dw == bsw_pkg::OFF_IRQ_BCTL) && cfg_be_i[2] &&
      (cfg_port_i == 2'h0) && cfg_wdata_i[bsw_pkg::BCTL_LSB + bsw_pkg::BC_SBR];
  endsequence

  chk_pf_lim_write: assert property (
    s_full_wr(bsw_pkg::OFF_PF_LIM_HI) |=> (pf_lim_hi_q[$past(cfg_port_i)] == $past(cfg_wdata_i)))
    else $error("prefetch limit upper dword not written");

  chk_pf_base_write: assert property (
    s_full_wr(bsw_pkg::OFF_PF_BASE_HI) |=>
      (pf_base_hi_q[$past(cfg_port_i)] == $past(cfg_wdata_i)))
    else $error("prefetch base upper dword not written");

  chk_io_halves_write: assert property (
    s_full_wr(bsw_pkg::OFF_IO_HI) |=>
      ((io_base_hi_q[$past(cfg_port_i)] == $past(cfg_wdata_i[15:0])) &&
       (io_lim_hi_q[$past(cfg_port_i)] == $past(cfg_wdata_i[31:16]))))
    else $error("io window halves not written");

  chk_cap_ptr_read: assert property (
    (cfg_req_i && !cfg_wr_i && (cfg_dw == bsw_pkg::OFF_CAP_PTR)) |=>
      (cfg_ack_o && (cfg_rdata_o == 32'h0000_0040)))
    else $error("capability pointer read wrong");

  chk_bctl_rsvd_zero: assert property (
    (cfg_req_i && !cfg_wr_i && (cfg_dw == bsw_pkg::OFF_IRQ_BCTL) && (cfg_port_i == 2'h0)) |=>
      ((cfg_rdata_o[31:23] == 9'h000) && !cfg_rdata_o[21] && (cfg_rdata_o[15:8] == 8'h00)))
    else $error("hardwired control or pin bits not zero");

  chk_poison_gate: assert property (
    poison_report_o[1] |-> $past(sec_poison_i[1] && bctl_q[1][bsw_pkg::BC_PERR]))
    else $error("poison reported while disabled");

  chk_err_forward: assert property (
    (sec_err_msg_i[1] && err_en[1]) |=> pri_err_msg_o)
    else $error("enabled error message not forwarded");

  chk_err_block: assert property (
    pri_err_msg_o |-> $past(|(sec_err_msg_i & err_en)))
    else $error("error message forwarded while disabled");

  chk_up_hot_reset: assert property (
    s_up_sbr_set |-> ##2 (hot_rst_n_o == 3'b000))
    else $error("upstream hot reset not fanned out");

  chk_dn_hot_reset: assert property (
    (!bctl_q[0][bsw_pkg::BC_SBR] && !bctl_q[3][bsw_pkg::BC_SBR]) |=> hot_rst_n_o[2])
    else $error("downstream reset asserted without cause");

  chk_vga_mem_fwd: assert property (
    (txn_req_i && !txn_is_io_i && dec_if.vga_en && (txn_addr_i == 64'h0000_0000_000A_0000))
      |=> (fwd_vld_o && fwd_vga_o))
    else $error("display memory access not forwarded");

  chk_vga_io_fwd: assert property (
    (txn_req_i && txn_is_io_i && dec_if.vga_en && !dec_if.vga16 &&
     (txn_addr_i == 64'h0000_0000_0000_13C0)) |=> fwd_vga_o)
    else $error("aliased display io not forwarded in 10 bit mode");

  chk_isa_block: assert property (
    (txn_req_i && txn_is_io_i && dec_if.isa_en && (txn_addr_i[63:16] == 48'h0) &&
     (txn_addr_i[9:8] == 2'b00)) |=> !fwd_hit_o)
    else $error("low quarter of 1KB block forwarded with alias filter");

  chk_empty_window: assert property (
    (txn_req_i && !txn_is_io_i && (dec_if.pf_lim < dec_if.pf_base)) |=> !fwd_hit_o)
    else $error("inverted prefetch window matched");

  chk_dn_reset_drive: assert property (
    bctl_q[2][bsw_pkg::BC_SBR] |=> !hot_rst_n_o[1])
    else $error("downstream port hot reset not asserted");

  chk_irq_line_write: assert property (
    (cfg_req_i && cfg_wr_i && (cfg_dw == bsw_pkg::OFF_IRQ_BCTL) && cfg_be_i[0]) |=>
      (irq_line_q[$past(cfg_port_i)] == $past(cfg_wdata_i[7:0])))
    else $error("interrupt line byte not written");

  chk_pin_write_ignored: assert property (
    (cfg_req_i && cfg_wr_i && (cfg_dw == bsw_pkg::OFF_IRQ_BCTL) && !init_ld_vld_i) |=>
      (pin_w[$past(cfg_port_i)] == $past(pin_w[cfg_port_i])))
    else $error("interrupt pin byte changed by a write");

  chk_rsvd_bit_write: assert property (
    s_full_wr(bsw_pkg::OFF_IRQ_BCTL) |=> (bctl_q[$past(cfg_port_i)][5] == 1'b0))
    else $error("hardwired control bit took a write");

  chk_poison_pass: assert property (
    (sec_poison_i[1] && bctl_q[1][bsw_pkg::BC_PERR]) |=> poison_report_o[1])
    else $error("enabled poison report not raised");

endmodule : bsw_bridge_regs

/* File: verification/bsw_host_model.sv */
`timescale 1ns/10ps
module bsw_host_model (
  input  wire logic                        mclk_i,
  input  wire logic                        cfg_ack_i,
  input  wire logic [31:0]                 cfg_rdata_i,
  output logic                             cfg_req_o,
  output logic                             cfg_wr_o,
  output logic      [bsw_pkg::PORT_W-1:0]  cfg_port_o,
  output logic      [7:0]                  cfg_addr_o,
  output logic      [3:0]                  cfg_be_o,
  output logic      [31:0]                 cfg_wdata_o
);
  initial begin
    cfg_req_o   = 1'b0;
    cfg_wr_o    = 1'b0;
    cfg_port_o  = '0;
    cfg_addr_o  = 8'h00;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h0000_0000;
  end

  // One dword access. Released qualifiers other than the port are inverted so a stale value never looks valid.
  task automatic access(input logic wr, input logic [bsw_pkg::PORT_W-1:0] port,
                        input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(posedge mclk_i);
    #1;
    cfg_req_o   = 1'b1;
    cfg_wr_o    = wr;
    cfg_port_o  = port;
    cfg_addr_o  = addr;
    cfg_be_o    = be;
    cfg_wdata_o = wd;
    @(posedge mclk_i);
    #1;
    cfg_req_o   = 1'b0;
    cfg_wr_o    = ~wr;
    cfg_addr_o  = ~addr;
    cfg_be_o    = ~be;
    cfg_wdata_o = ~wd;
    ack         = cfg_ack_i;
    rd          = cfg_rdata_i;
  endtask : access
endmodule : bsw_host_model

/* File: verification/test_bridge_window_and_control_regs.sv */
`timescale 1ns/10ps
module test_bridge_window_and_control_regs;
  logic                               mclk_i;
  logic                               sys_rst_i;
  logic                               cq, cw, ck, ld_vld, txn_req, txn_io;
  logic                               fwd_vld, fwd_hit, fwd_vga, pri_err;
  logic [bsw_pkg::PORT_W-1:0]         cp, ld_port, txn_port;
  logic [7:0]                         ca, ld_pin;
  logic [3:0]                         cb, poison, p_rep, err_msg;
  logic [31:0]                        cwd, crd;
  logic [63:0]                        txn_addr;
  logic [bsw_pkg::NPORT-1:0][11:0]    pf_b, pf_l;
  logic [bsw_pkg::NPORT-1:0][3:0]     io_b, io_l;
  logic [2:0]                         hot_n;
  int                                 n_errors;
  int                                 cmp_count;

  bsw_host_model host (.mclk_i(mclk_i), .cfg_ack_i(ck), .cfg_rdata_i(crd), .cfg_req_o(cq),
    .cfg_wr_o(cw), .cfg_port_o(cp), .cfg_addr_o(ca), .cfg_be_o(cb), .cfg_wdata_o(cwd));

  bsw_bridge_regs uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cfg_req_i(cq), .cfg_wr_i(cw),
    .cfg_port_i(cp), .cfg_addr_i(ca), .cfg_be_i(cb), .cfg_wdata_i(cwd), .cfg_ack_o(ck),
    .cfg_rdata_o(crd), .init_ld_vld_i(ld_vld), .init_ld_port_i(ld_port),
    .init_ld_pin_i(ld_pin), .pf_base_lo_i(pf_b), .pf_lim_lo_i(pf_l), .io_base_lo_i(io_b),
    .io_lim_lo_i(io_l), .txn_req_i(txn_req), .txn_port_i(txn_port), .txn_is_io_i(txn_io),
    .txn_addr_i(txn_addr), .fwd_vld_o(fwd_vld), .fwd_hit_o(fwd_hit), .fwd_vga_o(fwd_vga),
    .sec_poison_i(poison), .poison_report_o(p_rep), .sec_err_msg_i(err_msg),
    .pri_err_msg_o(pri_err), .hot_rst_n_o(hot_n));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [1:0] p, input logic [7:0] a, input logic [31:0] e);
    logic        ack;
    logic [31:0] d;
    host.access(1'b0, p, a, 4'h0, 32'h0000_0000, ack, d);
    chk({ack, d}, {1'b1, e});
  endtask : rd

  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] v);
    logic        ack;
    logic [31:0] d;
    host.access(1'b1, p, a, be, v, ack, d);
    chk({ack, d}, {1'b1, 32'h0000_0000});
  endtask : wr

  task automatic dec(input logic [1:0] p, input logic io, input logic [63:0] a,
                     input logic h, input logic v);
    @(posedge mclk_i);
    #1;
    txn_req  = 1'b1;
    txn_port = p;
    txn_io   = io;
    txn_addr = a;
    @(posedge mclk_i);
    #1;
    txn_req  = 1'b0;
    txn_addr = ~a;
    chk({fwd_vld, fwd_hit, fwd_vga}, {1'b1, h, v});
  endtask : dec

  task automatic t_reset();
    rd(2'h0, 8'h2C, 32'h0000_0000);
    rd(2'h3, 8'h30, 32'h0000_0000);
    rd(2'h1, 8'h34, 32'h0000_0040);
    rd(2'h2, 8'h3C, 32'h0000_0000);
    rd(2'h0, 8'h28, 32'h0000_0000);
    chk(hot_n, 3'h7);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(2'h1, 8'h2C, 4'hF, 32'hA5A5_5A5A);
    rd(2'h1, 8'h2C, 32'hA5A5_5A5A);
    rd(2'h2, 8'h2C, 32'h0000_0000);
    wr(2'h1, 8'h30, 4'h3, 32'h1234_5678);
    rd(2'h1, 8'h30, 32'h0000_5678);
    wr(2'h1, 8'h30, 4'hC, 32'h9ABC_0000);
    rd(2'h1, 8'h30, 32'h9ABC_5678);
    wr(2'h1, 8'h28, 4'hF, 32'hCAFE_0001);
    rd(2'h1, 8'h28, 32'hCAFE_0001);
    wr(2'h1, 8'h34, 4'hF, 32'hFFFF_FFFF);
    rd(2'h1, 8'h34, 32'h0000_0040);
    wr(2'h3, 8'h3C, 4'hF, 32'hFFFF_FFFF);
    rd(2'h3, 8'h3C, 32'h005F_00FF);
    wr(2'h3, 8'h3C, 4'hF, 32'h0000_0000);
    rd(2'h1, 8'h50, 32'h0000_0000);
    $display("test registers done");
  endtask : t_regs

  task automatic t_pin();
    @(posedge mclk_i);
    #1;
    ld_vld  = 1'b1;
    ld_port = 2'h2;
    ld_pin  = 8'h01;
    @(posedge mclk_i);
    #1;
    ld_port = 2'h0;
    ld_pin  = 8'hA5;
    @(posedge mclk_i);
    #1;
    ld_vld = 1'b0;
    rd(2'h2, 8'h3C, 32'h0000_0100);
    rd(2'h0, 8'h3C, 32'h0000_0000);
    wr(2'h2, 8'h3C, 4'h2, 32'h0000_FF00);
    rd(2'h2, 8'h3C, 32'h0000_0100);
    $display("test interrupt pin done");
  endtask : t_pin

  task automatic t_err();
    wr(2'h1, 8'h3C, 4'h4, 32'h0003_0000);
    @(posedge mclk_i);
    #1;
    poison  = 4'h6;
    err_msg = 4'h6;
    @(posedge mclk_i);
    #1;
    chk({p_rep, pri_err}, {4'h2, 1'b1});
    poison  = 4'h0;
    err_msg = 4'h4;
    @(posedge mclk_i);
    #1;
    chk({p_rep, pri_err}, {4'h0, 1'b0});
    err_msg = 4'h0;
    wr(2'h1, 8'h3C, 4'h4, 32'h0000_0000);
    $display("test error gating done");
  endtask : t_err

  task automatic t_hot();
    wr(2'h2, 8'h3C, 4'h4, 32'h0040_0000);
    @(posedge mclk_i);
    #1;
    chk(hot_n, 3'h5);
    wr(2'h2, 8'h3C, 4'h4, 32'h0000_0000);
    @(posedge mclk_i);
    #1;
    chk(hot_n, 3'h7);
    wr(2'h0, 8'h3C, 4'h4, 32'h0040_0000);
    @(posedge mclk_i);
    #1;
    chk(hot_n, 3'h0);
    wr(2'h0, 8'h3C, 4'h4, 32'h0000_0000);
    $display("test hot reset done");
  endtask : t_hot

  task automatic t_dec();
    wr(2'h1, 8'h28, 4'hF, 32'h0000_0001);
    wr(2'h1, 8'h2C, 4'hF, 32'h0000_0001);
    pf_b[1] = 12'h010;
    pf_l[1] = 12'h020;
    dec(2'h1, 1'b0, 64'h1_0100_0000, 1'b1, 1'b0);
    dec(2'h1, 1'b0, 64'h1_00FF_FFFF, 1'b0, 1'b0);
    dec(2'h1, 1'b0, 64'h1_020F_FFFF, 1'b1, 1'b0);
    dec(2'h1, 1'b0, 64'h1_0210_0000, 1'b0, 1'b0);
    pf_l[1] = 12'h00F;
    dec(2'h1, 1'b0, 64'h1_0100_0000, 1'b0, 1'b0);
    wr(2'h1, 8'h30, 4'hF, 32'h0000_0000);
    io_l[1] = 4'hF;
    dec(2'h1, 1'b1, 64'h100, 1'b1, 1'b0);
    wr(2'h1, 8'h3C, 4'h4, 32'h0004_0000);
    dec(2'h1, 1'b1, 64'h400, 1'b0, 1'b0);
    dec(2'h1, 1'b1, 64'h500, 1'b1, 1'b0);
    wr(2'h1, 8'h3C, 4'h4, 32'h0008_0000);
    dec(2'h1, 1'b0, 64'hA_0000, 1'b0, 1'b1);
    dec(2'h1, 1'b0, 64'hB_FFFF, 1'b0, 1'b1);
    dec(2'h1, 1'b0, 64'hC_0000, 1'b0, 1'b0);
    dec(2'h1, 1'b1, 64'h3B0, 1'b1, 1'b1);
    dec(2'h1, 1'b1, 64'h3BC, 1'b1, 1'b0);
    dec(2'h1, 1'b1, 64'h3DF, 1'b1, 1'b1);
    dec(2'h1, 1'b1, 64'h13C0, 1'b1, 1'b1);
    wr(2'h1, 8'h3C, 4'h4, 32'h0018_0000);
    dec(2'h1, 1'b1, 64'h13C0, 1'b1, 1'b0);
    dec(2'h1, 1'b1, 64'h3C0, 1'b1, 1'b1);
    wr(2'h1, 8'h3C, 4'h4, 32'h0000_0000);
    dec(2'h1, 1'b0, 64'hA_0000, 1'b0, 1'b0);
    $display("test decode done");
  endtask : t_dec

  // Guards against a hung sequence; the run normally needs about 125 cycles.
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial begin
    n_errors  = 0;
    cmp_count = 0;
    sys_rst_i = 1'b1;
    ld_vld    = 1'b0;
    ld_port   = '0;
    ld_pin    = 8'h00;
    pf_b      = '0;
    pf_l      = '0;
    io_b      = '0;
    io_l      = '0;
    txn_req   = 1'b0;
    txn_port  = '0;
    txn_io    = 1'b0;
    txn_addr  = 64'h0;
    poison    = 4'h0;
    err_msg   = 4'h0;
    repeat (6) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_regs();
    t_pin();
    t_err();
    t_hot();
    t_dec();
    give_verdict();
  end
endmodule : test_bridge_window_and_control_regs
